// ### core/lamp_chopping_pwm_defs.svh
// Constants for the lamp brightness and chopping PWM block
`ifndef LAMP_CHOPPING_PWM_DEFS_SVH
`define LAMP_CHOPPING_PWM_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define SYS_CLK_MHZ 250
`define MIN_OFF_NS 375
// Least time: round up
`define MIN_OFF_CYC ((`MIN_OFF_NS * `SYS_CLK_MHZ + 999) / 1000)
`define LAMP_OUT_MS 2000
// Longest time: round down
`define LAMP_OUT_CYC (`LAMP_OUT_MS * `SYS_CLK_MHZ * 1000)

// ----------------------------------------------------------------------
// Brightness code and chopping
// ----------------------------------------------------------------------
`define CODE_W 5
`define CODE_ZERO 5'h00
`define CODE_MAX 5'h1f
`define CODE_FLOOR 5'h03
`define WEIGHT_FULL 6'h20
`define CHOP_CNT_W 7
`define TICK_W 8
`define FLOOR_TICKS 8'h0c
`define FULL_TICKS 8'h80
`define ADC_W 6
`define ADC_FULL 6'h20
`define OFF_CNT_W 7
`define LAMP_CNT_W 32

`endif

// ### core/lamp_chopping_pwm_pkg.sv
// Types for the lamp brightness and chopping PWM block
package lamp_chopping_pwm_pkg;

  typedef enum logic [1:0] {
    MODE_DIGITAL,
    MODE_ANALOG_NEG,
    MODE_ANALOG_POS
  } iface_mode_t;

  typedef enum logic {
    BUCK_OFF,
    BUCK_ON
  } buck_state_t;

  // Mode pin comparator pair
  typedef struct packed {
    logic at_rail;
    logic at_ref;
  } mode_level_t;

  // Word handed to the link domain
  typedef struct packed {
    logic disable_chop;
    logic [4:0] code;
  } xfer_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic trip_s1;
    logic trip_s2;
    logic lim_s1;
    logic lim_s2;
    logic lok_s1;
    logic lok_s2;
    mode_level_t mode_s1;
    mode_level_t mode_s2;
    logic minr_s1;
    logic minr_s2;
    logic shdn_s1;
    logic shdn_s2;
    logic [5:0] adc_s1;
    logic [5:0] adc_s2;
    logic [5:0] adc_d;
    logic chop_s1;
    logic chop_s2;
    logic ack_s1;
    logic ack_s2;
    iface_mode_t mode;
    logic [4:0] code;
    buck_state_t buck;
    logic pend;
    logic [6:0] off_cnt;
    logic [31:0] lamp_cnt;
    logic fault;
    logic req;
    logic busy;
    xfer_t xfer;
  } sys_state_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    xfer_t held;
    logic [6:0] cnt;
    logic chop_on;
  } link_state_t;

endpackage

// ### core/lamp_brightness_chopping_pwm_control.sv
// Brightness code, current weights, buck timing, chopping PWM and lamp-out timer
`timescale 1ns/100ps
`include "lamp_chopping_pwm_defs.svh"

module lamp_brightness_chopping_pwm_control #(
  parameter int unsigned LAMP_OUT_CYCLES = `LAMP_OUT_CYC,
  parameter int unsigned MIN_OFF_CYCLES = `MIN_OFF_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_sync_clk,
  input wire logic i_commutation_sense,
  input wire logic i_pwm_trip,
  input wire logic i_current_limit,
  input wire logic i_averaged_current_sense_ok,
  input wire lamp_chopping_pwm_pkg::mode_level_t i_mode_level,
  input wire logic i_minimum_level_input_at_rail,
  input wire logic i_shutdown_suspend_pin,
  input wire logic [5:0] i_adc_level,
  input wire logic [4:0] i_bus_code,
  input wire logic i_bus_shutdown,
  output logic o_high_side_drive,
  output lamp_chopping_pwm_pkg::iface_mode_t o_iface_mode,
  output logic o_pins_are_bus,
  output logic o_bus_suspend,
  output logic [4:0] o_brightness_code,
  output logic [4:0] o_ref_weight,
  output logic [5:0] o_min_weight,
  output logic o_chopping_pwm,
  output logic o_current_loop_active,
  output logic o_lamp_enable,
  output logic o_lamp_out_fault
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  // The off-time counter must not wrap before it reaches its target
  if (LAMP_OUT_CYCLES < 2 || MIN_OFF_CYCLES < 1 ||
      MIN_OFF_CYCLES > (1 << `OFF_CNT_W) - 1)
  begin : g_bad_timing
    $error("lamp_brightness_chopping_pwm_control: unsupported timing parameters");
  end

  localparam logic [`OFF_CNT_W-1:0] MIN_OFF = `OFF_CNT_W'(MIN_OFF_CYCLES);
  localparam logic [`LAMP_CNT_W-1:0] LAMP_LAST = `LAMP_CNT_W'(LAMP_OUT_CYCLES - 1);

  lamp_chopping_pwm_pkg::sys_state_t s_r;
  lamp_chopping_pwm_pkg::sys_state_t s_nxt;
  lamp_chopping_pwm_pkg::link_state_t l_r;
  lamp_chopping_pwm_pkg::link_state_t l_nxt;

  logic [5:0] scaled;
  logic shutdown;
  logic run;
  logic [`TICK_W-1:0] on_ticks;

  // ----------------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    scaled = '0;
    shutdown = 1'b0;
    run = 1'b0;
    // Synchronisers: stage one feeds only stage two
    s_nxt.cs_s1 = i_commutation_sense;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.cs_d = s_r.cs_s2;
    s_nxt.trip_s1 = i_pwm_trip;
    s_nxt.trip_s2 = s_r.trip_s1;
    s_nxt.lim_s1 = i_current_limit;
    s_nxt.lim_s2 = s_r.lim_s1;
    s_nxt.lok_s1 = i_averaged_current_sense_ok;
    s_nxt.lok_s2 = s_r.lok_s1;
    s_nxt.mode_s1 = i_mode_level;
    s_nxt.mode_s2 = s_r.mode_s1;
    s_nxt.minr_s1 = i_minimum_level_input_at_rail;
    s_nxt.minr_s2 = s_r.minr_s1;
    s_nxt.shdn_s1 = i_shutdown_suspend_pin;
    s_nxt.shdn_s2 = s_r.shdn_s1;
    s_nxt.adc_s1 = i_adc_level;
    s_nxt.adc_s2 = s_r.adc_s1;
    s_nxt.adc_d = s_r.adc_s2;
    s_nxt.chop_s1 = l_r.chop_on;
    s_nxt.chop_s2 = s_r.chop_s1;
    s_nxt.ack_s1 = l_r.ack;
    s_nxt.ack_s2 = s_r.ack_s1;

    if (s_r.mode_s2.at_rail)
      s_nxt.mode = lamp_chopping_pwm_pkg::MODE_DIGITAL;
    else if (s_r.mode_s2.at_ref)
      s_nxt.mode = lamp_chopping_pwm_pkg::MODE_ANALOG_NEG;
    else
      s_nxt.mode = lamp_chopping_pwm_pkg::MODE_ANALOG_POS;

    if (s_r.mode == lamp_chopping_pwm_pkg::MODE_DIGITAL)
    begin
      s_nxt.code = i_bus_code;
    end
    else if (s_r.adc_s2 == s_r.adc_d)
    begin
      // Two agreeing samples guard against a multi-bit level caught mid-change
      // orientation and hysteresis
      if (s_r.mode == lamp_chopping_pwm_pkg::MODE_ANALOG_NEG)
        scaled = (s_r.adc_s2 >= `ADC_FULL) ? 6'h00 : `ADC_FULL - s_r.adc_s2;
      else
        scaled = s_r.adc_s2;
      if (s_r.code != `CODE_MAX && scaled >= {1'b0, s_r.code} + 6'h02)
        s_nxt.code = s_r.code + 5'h01;
      else if (s_r.code != `CODE_ZERO && scaled < {1'b0, s_r.code})
        s_nxt.code = s_r.code - 5'h01;
    end

    // shutdown pin is active-low shutdown in analog, suspend in digital
    if (s_r.mode == lamp_chopping_pwm_pkg::MODE_DIGITAL)
      shutdown = i_bus_shutdown;
    else
      shutdown = !s_r.shdn_s2;

    // lamp-out timer; shutdown releases the latch
    if (shutdown)
    begin
      s_nxt.fault = 1'b0;
      s_nxt.lamp_cnt = '0;
    end
    else if (!s_r.fault)
    begin
      if (s_r.lok_s2)
        s_nxt.lamp_cnt = '0;
      else if (s_r.lamp_cnt == LAMP_LAST)
        s_nxt.fault = 1'b1;
      else
        s_nxt.lamp_cnt = s_r.lamp_cnt + 32'h00000001;
    end
    run = !shutdown && !s_r.fault;

    // Off-time counter saturates at the minimum
    if (s_r.buck == lamp_chopping_pwm_pkg::BUCK_ON)
      s_nxt.off_cnt = '0;
    else if (s_r.off_cnt != MIN_OFF)
      s_nxt.off_cnt = s_r.off_cnt + 7'h01;

    if (s_r.cs_d && !s_r.cs_s2)
      s_nxt.pend = 1'b1;
    unique case (s_r.buck)
      lamp_chopping_pwm_pkg::BUCK_OFF:
      begin
        if (!run || !s_r.chop_s2)
        begin
          s_nxt.pend = 1'b0;
        end
        // start only after the minimum off-time
        else if (s_r.pend && s_r.off_cnt == MIN_OFF && !s_r.trip_s2 && !s_r.lim_s2)
        begin
          s_nxt.buck = lamp_chopping_pwm_pkg::BUCK_ON;
          s_nxt.pend = 1'b0;
        end
      end
      lamp_chopping_pwm_pkg::BUCK_ON:
      begin
        // first of comparator or current limit ends the cycle
        if (s_r.trip_s2 || s_r.lim_s2 || !run || !s_r.chop_s2)
          s_nxt.buck = lamp_chopping_pwm_pkg::BUCK_OFF;
      end
    endcase

    // Handshake towards the link domain; word is held until acknowledged
    if (s_r.busy)
    begin
      if (s_r.ack_s2 == s_r.req)
        s_nxt.busy = 1'b0;
    end
    else if (s_r.xfer.code != s_r.code || s_r.xfer.disable_chop != s_r.minr_s2)
    begin
      s_nxt.xfer.code = s_r.code;
      s_nxt.xfer.disable_chop = s_r.minr_s2;
      s_nxt.req = !s_r.req;
      s_nxt.busy = 1'b1;
    end

    if (i_reset)
      s_nxt = '0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------------
  // Link domain: chopping period on the mode-pin sync pulses
  // ----------------------------------------------------------------------
  // A new code takes effect mid-period; the tick counter runs free on sync pulses
  // on-tick count with low-code floor
  // duty steps of 4 ticks in 128
  assign on_ticks = (l_r.held.code <= `CODE_FLOOR) ? `FLOOR_TICKS :
                    {1'b0, l_r.held.code, 2'b00} + 8'h04;

  always_comb
  begin
    l_nxt = l_r;
    l_nxt.rst_s1 = i_reset;
    l_nxt.rst_s2 = l_r.rst_s1;
    l_nxt.req_s1 = s_r.req;
    l_nxt.req_s2 = l_r.req_s1;
    if (l_r.req_s2 != l_r.ack)
    begin
      l_nxt.held = s_r.xfer;
      l_nxt.ack = l_r.req_s2;
    end
    l_nxt.cnt = l_r.cnt + 7'h01;
    l_nxt.chop_on = l_r.held.disable_chop || ({1'b0, l_nxt.cnt} < on_ticks);
    if (l_r.rst_s2)
    begin
      l_nxt.held = '0;
      l_nxt.ack = 1'b0;
      l_nxt.cnt = '0;
      l_nxt.chop_on = 1'b0;
    end
  end

  always_ff @(posedge i_sync_clk)
  begin
    l_r <= l_nxt;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_high_side_drive = (s_r.buck == lamp_chopping_pwm_pkg::BUCK_ON);
  assign o_iface_mode = s_r.mode;
  // shared pin roles follow the mode
  assign o_pins_are_bus = (s_r.mode == lamp_chopping_pwm_pkg::MODE_DIGITAL);
  assign o_bus_suspend = o_pins_are_bus && s_r.shdn_s2;
  assign o_brightness_code = s_r.code;
  // reference n, minimum level 32-n, over 32
  // with minimum level at reference the sum is full scale at any code
  assign o_ref_weight = s_r.code;
  assign o_min_weight = s_r.minr_s2 ? 6'h00 : `WEIGHT_FULL - {1'b0, s_r.code};
  assign o_chopping_pwm = s_r.chop_s2;
  // current loop held during chopping off-time
  assign o_current_loop_active = s_r.chop_s2 && o_lamp_enable;
  assign o_lamp_enable = !s_r.fault && !(o_pins_are_bus ? i_bus_shutdown : !s_r.shdn_s2);
  assign o_lamp_out_fault = s_r.fault;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  AST_MIN_OFF: assert property (
    $rose(o_high_side_drive) |-> $past(s_r.off_cnt) == MIN_OFF)
    else $error("buck started before minimum off-time");
  AST_END_ON: assert property (
    o_high_side_drive && (s_r.trip_s2 || s_r.lim_s2) |=> !o_high_side_drive)
    else $error("on-cycle not ended by trip");
  AST_MODE_DECODE: assert property (
    s_r.mode_s2.at_rail |=> o_iface_mode == lamp_chopping_pwm_pkg::MODE_DIGITAL)
    else $error("rail mode level not decoded as digital");
  AST_PIN_ROLE: assert property (
    o_pins_are_bus == (o_iface_mode == lamp_chopping_pwm_pkg::MODE_DIGITAL))
    else $error("pin role disagrees with mode");
  AST_BUS_CODE: assert property (
    o_iface_mode == lamp_chopping_pwm_pkg::MODE_DIGITAL |=> o_brightness_code == $past(i_bus_code))
    else $error("code does not follow bus value");
  AST_WEIGHTS: assert property (
    !s_r.minr_s2 |-> {1'b0, o_ref_weight} + o_min_weight == `WEIGHT_FULL)
    else $error("weights do not sum to 32");
  AST_LAMP_OUT: assert property (
    $rose(o_lamp_out_fault) |-> $past(s_r.lamp_cnt) == LAMP_LAST && !$past(s_r.lok_s2))
    else $error("lamp-out latched at wrong count");
  AST_FAULT_OFF: assert property (
    o_lamp_out_fault |=> !o_high_side_drive)
    else $error("drive on during lamp-out");
  AST_HYST: assert property (
    o_iface_mode != lamp_chopping_pwm_pkg::MODE_DIGITAL && $past(o_iface_mode) == o_iface_mode
    |=> o_brightness_code - $past(o_brightness_code) inside {5'h00, 5'h01, 5'h1f})
    else $error("analog code moved more than one step");
  AST_LOOP_HOLD: assert property (
    !o_chopping_pwm |-> !o_current_loop_active)
    else $error("current loop active in chopping off-time");
  AST_RESET: assert property (@(posedge i_sys_clk)
    $past(i_reset) |-> o_brightness_code == `CODE_ZERO && !o_lamp_out_fault && !o_high_side_drive)
    else $error("state not cleared by reset");
  AST_FLOOR: assert property (@(posedge i_sync_clk) disable iff (l_r.rst_s2)
    l_r.held.code <= `CODE_FLOOR && !l_r.held.disable_chop &&
    {1'b0, l_r.cnt} == `FLOOR_TICKS - 8'h01 |=> !l_r.chop_on)
    else $error("floor codes not at 12 ticks");
  AST_TICKS: assert property (@(posedge i_sync_clk) disable iff (l_r.rst_s2)
    l_r.held.code == `CODE_MAX |=> l_r.chop_on)
    else $error("full code not at 128 ticks");
  AST_RAIL_FULL: assert property (@(posedge i_sync_clk) disable iff (l_r.rst_s2)
    l_r.held.disable_chop |=> l_r.chop_on)
    else $error("chopping while disabled");
  AST_PERIOD: assert property (@(posedge i_sync_clk) disable iff (l_r.rst_s2)
    &l_r.cnt |=> l_r.cnt == 7'h00)
    else $error("chopping period not 128 ticks");
  // Drive must drop whenever the lamp is off or chopping is in its off-time
  AST_SHUT_OFF: assert property (
    !o_lamp_enable |=> !o_high_side_drive)
    else $error("drive on during shutdown");
  AST_CHOP_OFF: assert property (
    !o_chopping_pwm |=> !o_high_side_drive)
    else $error("drive on in chopping off-time");
  AST_FAULT_HOLD: assert property (
    o_lamp_out_fault && !shutdown |=> o_lamp_out_fault)
    else $error("lamp-out latch released without shutdown");

  COV_BUCK: cover property ($rose(o_high_side_drive));
  COV_FAULT: cover property ($rose(o_lamp_out_fault));
  COV_CHOP: cover property ($fell(o_chopping_pwm));
  COV_DIGITAL: cover property (o_iface_mode == lamp_chopping_pwm_pkg::MODE_DIGITAL);
  COV_NEG: cover property (o_iface_mode == lamp_chopping_pwm_pkg::MODE_ANALOG_NEG);

endmodule

// ### tb/brightness_source.sv
// Far-side model: mode pin with sync pulses, parallel host code and analog level
`timescale 1ns/100ps
module brightness_source (
  input wire logic i_sys_clk,
  input wire lamp_chopping_pwm_pkg::iface_mode_t i_mode_req,
  input wire logic [4:0] i_code_req,
  input wire logic [5:0] i_level_req,
  output logic o_sync_clk,
  output lamp_chopping_pwm_pkg::mode_level_t o_mode_level,
  output logic [4:0] o_bus_code,
  output logic [5:0] o_adc_level
);
  // Sync pulses run free on the mode pin, phase unrelated to the system clock
  initial
  begin
    o_sync_clk = 1'b0;
    #1.3;
    forever #3 o_sync_clk = ~o_sync_clk;
  end
  always_comb
  begin
    o_mode_level.at_rail = (i_mode_req == lamp_chopping_pwm_pkg::MODE_DIGITAL);
    o_mode_level.at_ref = (i_mode_req == lamp_chopping_pwm_pkg::MODE_ANALOG_NEG);
  end
  // Level moves only on a clock edge, so it holds at least one whole cycle
  initial
  begin
    o_bus_code = 5'h00;
    o_adc_level = 6'h00;
  end
  always @(posedge i_sys_clk)
  begin
    o_bus_code <= i_code_req;
    o_adc_level <= (i_level_req > 6'h20) ? 6'h20 : i_level_req;
  end
endmodule

// ### tb/lamp_brightness_chopping_pwm_control_bench.sv
// Self-checking bench for the lamp brightness and chopping PWM block
`timescale 1ns/100ps
module lamp_brightness_chopping_pwm_control_bench;
  localparam int LAMP_OUT = 200;
  localparam int MIN_OFF = 20;
  logic clk, rst, comm, trip, lim, sense_ok, min_rail, shdn_pin, bus_shdn, sync_clk;
  logic drive, pins_bus, suspend, chop, loop_act, lamp_en, fault;
  lamp_chopping_pwm_pkg::iface_mode_t mode_req, iface_mode;
  lamp_chopping_pwm_pkg::mode_level_t mode_level;
  logic [4:0] code_req, bus_code, code, ref_w;
  logic [5:0] level_req, adc_level, min_w;
  logic [31:0] seed;
  int bad_count, samples_checked, n, hi, act, exp_code;
  int corner[4] = '{0, 31, 3, 4};
  int lv_tab[5] = '{10, 0, 10, 10, 20};

  lamp_brightness_chopping_pwm_control #(.LAMP_OUT_CYCLES(LAMP_OUT), .MIN_OFF_CYCLES(MIN_OFF))
    lamp_brightness_chopping_pwm_control_inst (
    .i_sys_clk(clk), .i_reset(rst), .i_sync_clk(sync_clk), .i_commutation_sense(comm),
    .i_pwm_trip(trip), .i_current_limit(lim), .i_averaged_current_sense_ok(sense_ok),
    .i_mode_level(mode_level), .i_minimum_level_input_at_rail(min_rail),
    .i_shutdown_suspend_pin(shdn_pin), .i_adc_level(adc_level), .i_bus_code(bus_code),
    .i_bus_shutdown(bus_shdn), .o_high_side_drive(drive), .o_iface_mode(iface_mode),
    .o_pins_are_bus(pins_bus), .o_bus_suspend(suspend), .o_brightness_code(code),
    .o_ref_weight(ref_w), .o_min_weight(min_w), .o_chopping_pwm(chop),
    .o_current_loop_active(loop_act), .o_lamp_enable(lamp_en), .o_lamp_out_fault(fault));

  brightness_source brightness_source_inst (.i_sys_clk(clk), .i_mode_req(mode_req),
    .i_code_req(code_req), .i_level_req(level_req), .o_sync_clk(sync_clk),
    .o_mode_level(mode_level), .o_bus_code(bus_code), .o_adc_level(adc_level));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int on_ticks(input int c);
    return (c <= 3) ? 12 : 4 * (c + 1);
  endfunction
  // Converter steps one code at a time until inside the hysteresis band
  function automatic int settle(input int c, input int lv, input bit neg);
    int m;
    m = neg ? 32 - lv : lv;
    while (m >= c + 2) c++;
    while (m < c) c--;
    return c;
  endfunction
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo, input int up, input int got);
    samples_checked++;
    if (got < lo || got > up)
    begin
      bad_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, up, got);
    end
  endtask
  task automatic wait_for(input bit on_fault, input logic v, input int limit, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
    end
    while ((on_fault ? fault : drive) !== v && cnt < limit);
    if ((on_fault ? fault : drive) !== v)
    begin
      bad_count++;
      $display("wrong value wait expected %0h seen %0h", v, on_fault ? fault : drive);
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {rst, comm, sense_ok, shdn_pin} = 4'hf;
    {trip, lim, min_rail, bus_shdn} = 4'h0;
    mode_req = lamp_chopping_pwm_pkg::MODE_DIGITAL;
    code_req = 5'h00;
    level_req = 6'h00;
    seed = 32'h0000003b;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    check_val("code", 0, code);
    check_val("fault", 0, fault);
    check_val("min weight", 32, min_w);
    check_val("chop", 0, chop);
    rst <= 1'b0;
    $display("test reset done");
    for (int m = 0; m < 3; m++)
      for (int j = 0; j < 2; j++)
      begin
        mode_req <= lamp_chopping_pwm_pkg::iface_mode_t'(m);
        shdn_pin <= j[0];
        repeat (8) @(posedge clk);
        check_val("mode", m, iface_mode);
        check_val("pins are bus", m == 0, pins_bus);
        check_val("suspend", m == 0 && j == 1, suspend);
        check_val("lamp enable", m == 0 || j == 1, lamp_en);
      end
    $display("test modes done");
    mode_req <= lamp_chopping_pwm_pkg::MODE_DIGITAL;
    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      act = (i < 4) ? corner[i] : seed[4:0];
      code_req <= act[4:0];
      min_rail <= seed[8];
      bus_shdn <= seed[9];
      repeat (6) @(posedge clk);
      check_val("code", act, code);
      check_val("ref weight", act, ref_w);
      check_val("min weight", seed[8] ? 0 : 32 - act, min_w);
      check_val("lamp enable", !seed[9], lamp_en);
    end
    bus_shdn <= 1'b0;
    $display("test digital code done");
    // Two whole chopping periods: 256 sync ticks equal 384 system cycles
    for (int i = 0; i < 7; i++)
    begin
      seed = xs(seed);
      act = (i < 4) ? corner[i] : seed[4:0];
      code_req <= act[4:0];
      min_rail <= (i == 6);
      repeat (400) @(posedge clk);
      hi = 0;
      n = 0;
      repeat (384)
      begin
        @(posedge clk);
        hi += (chop === 1'b1);
        n += (loop_act === 1'b1);
      end
      exp_code = (i == 6) ? 384 : 3 * on_ticks(act);
      check_range("duty", exp_code - 3, exp_code + 3, hi);
      check_range("loop active", exp_code - 3, exp_code + 3, n);
    end
    min_rail <= 1'b0;
    $display("test chopping done");
    mode_req <= lamp_chopping_pwm_pkg::MODE_ANALOG_POS;
    level_req <= 6'h20;
    repeat (80) @(posedge clk);
    exp_code = 31;
    check_val("analog code", 31, code);
    for (int i = 0; i < 7; i++)
    begin
      seed = xs(seed);
      act = (i < 5) ? lv_tab[i] : ((i == 5) ? seed[7:0] % 33 : 0);
      mode_req <= (i < 3) ? lamp_chopping_pwm_pkg::MODE_ANALOG_POS : lamp_chopping_pwm_pkg::MODE_ANALOG_NEG;
      level_req <= act[5:0];
      repeat (80) @(posedge clk);
      exp_code = settle(exp_code, act, i >= 3);
      check_val("analog code", exp_code, code);
    end
    $display("test analog done");
    hi = 0;
    repeat (60)
    begin
      @(posedge clk);
      hi += (drive !== 1'b0);
    end
    check_range("idle drive", 0, 0, hi);
    for (int k = 0; k < 2; k++)
    begin
      comm <= 1'b0;
      wait_for(1'b0, 1'b1, MIN_OFF + 40, n);
      trip <= (k == 0);
      lim <= (k == 1);
      wait_for(1'b0, 1'b0, 10, n);
      check_range("on end", 2, 5, n);
      {trip, lim, comm} <= 3'b001;
      @(posedge clk);
      comm <= 1'b0;
      wait_for(1'b0, 1'b1, MIN_OFF + 40, n);
      check_range("off time", MIN_OFF, MIN_OFF + 4, n + 1);
    end
    $display("test buck done");
    sense_ok <= 1'b0;
    wait_for(1'b1, 1'b1, LAMP_OUT + 40, n);
    check_range("lamp out", LAMP_OUT, LAMP_OUT + 6, n);
    repeat (2) @(posedge clk);
    check_val("lamp enable", 0, lamp_en);
    check_val("drive", 0, drive);
    check_val("loop active", 0, loop_act);
    $display("test lamp out done");
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    check_val("fault", 0, fault);
    check_val("code", 0, code);
    check_val("drive", 0, drive);
    rst <= 1'b0;
    $display("test second reset done");
    end_sim();
  end
endmodule
